/* pkg/sspcl_defs.vh */
`ifndef SSPCL_DEFS_VH
`define SSPCL_DEFS_VH

// ***************************************************
// Clock and timing
// ***************************************************
// Counts in 20 ns clock cycles
`define SSPCL_CYC_1US 50
`define SSPCL_CYC_HALF_US 25
`define SSPCL_CYC_4US 200

// ***************************************************
// Register byte offsets
// ***************************************************
`define SSPCL_ADDR_CTRL 8'h00
`define SSPCL_ADDR_MIN_SHIFT 8'h04
`define SSPCL_ADDR_DT_SD 8'h08
`define SSPCL_ADDR_FLOOR_SPEED 8'h0C
`define SSPCL_ADDR_STARTUP_CAP 8'h10
`define SSPCL_ADDR_SLOPE 8'h14
`define SSPCL_ADDR_FULL_CAP 8'h18
`define SSPCL_ADDR_BRAKE_THR 8'h1C
`define SSPCL_ADDR_BRAKE_CAP 8'h20
`define SSPCL_ADDR_STATUS 8'h24
`define SSPCL_ADDR_LIMIT 8'h28
`define SSPCL_ADDR_SAMPLE_PTS 8'h2C

// ***************************************************
// Field positions and reset values
// ***************************************************
`define SSPCL_CTRL_SINGLE_SHUNT 0
`define SSPCL_CTRL_LOW_NOISE 1
`define SSPCL_LO_MSB 15
`define SSPCL_HI_LSB 16
`define SSPCL_RST_CTRL 2'h1
`define SSPCL_RST_MIN_SHIFT 16'h0000
`define SSPCL_RST_WORD 16'h0000
`define SSPCL_RST_FULL_CAP 16'h7FFF

`endif

/* src/sspcl_sample_sched.v */
`include "sspcl_defs.vh"
`default_nettype none

// ***************************************************
// Sample point scheduler for peak tracking
// ***************************************************
module sspcl_sample_sched #(
   parameter W = 16
) (
   input wire clk,
   input wire rst_b,
   input wire load,
   input wire low_noise,
   input wire [W-1:0] period,
   input wire [W-1:0] ta,
   input wire [W-1:0] tb,
   input wire [W-1:0] a_start,
   input wire [W-1:0] b_start,
   input wire [W-1:0] zero_start,
   input wire [W-1:0] dead_time,
   input wire [W-1:0] sampling_delay,
   output reg [W-1:0] first_sample_point,
   output reg [W-1:0] second_sample_point
);

   localparam [W:0] ONE_US = `SSPCL_CYC_1US;
   localparam [W:0] HALF_US = `SSPCL_CYC_HALF_US;
   localparam [W:0] FOUR_US = `SSPCL_CYC_4US;

   // Keep a point inside the cycle so the sample lands before the next FOC run
   function [W-1:0] clamp;
      input [W+1:0] v;
      input [W-1:0] p;
      begin
         if (v >= {2'b00, p})
            clamp = p - {{(W-1){1'b0}}, 1'b1};
         else
            clamp = v[W-1:0];
      end
   endfunction

   reg [W+1:0] cs1_raw;
   reg [W+1:0] cs2_raw;
   reg [W+1:0] common;

   // ***************************************************
   // Point arithmetic
   // ***************************************************
   always @* begin
      common = {2'b00, dead_time} + {2'b00, sampling_delay};
      if (!low_noise) begin
         // Normal scheme: mid window plus dead time and sampling delay
         if ({1'b0, tb} < ONE_US)
            cs1_raw = {1'b0, HALF_US};
         else
            cs1_raw = {2'b00, b_start} + {3'b000, tb[W-1:1]} + common;
         if ({1'b0, ta} < ONE_US)
            cs2_raw = {2'b00, period} - {1'b0, HALF_US};
         else
            cs2_raw = {2'b00, a_start} + {3'b000, ta[W-1:1]} + common;
      end else begin
         // Low noise scheme: full time plus delays and one microsecond guard
         if ({1'b0, ta} < ONE_US) begin
            // Early start would fall before the cycle: sample just after it
            if ({1'b0, a_start} <= ONE_US)
               cs1_raw = {{(W+1){1'b0}}, 1'b1};
            else
               cs1_raw = {2'b00, a_start} - {1'b0, ONE_US};
         end else begin
            cs1_raw = {2'b00, a_start} + {2'b00, ta} + common + {1'b0, ONE_US};
         end
         if ({1'b0, tb} < ONE_US)
            cs2_raw = {2'b00, zero_start} + {1'b0, FOUR_US};
         else
            cs2_raw = {2'b00, b_start} + {2'b00, tb} + common + {1'b0, ONE_US};
      end
   end

   // ***************************************************
   // Points held for one whole PWM cycle
   // ***************************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         first_sample_point <= {W{1'b0}};
         second_sample_point <= {W{1'b0}};
      end else if (load) begin
         first_sample_point <= clamp(cs1_raw, period);
         second_sample_point <= clamp(cs2_raw, period);
      end
   end

endmodule

`default_nettype wire

/* src/sspcl_limit.v */
`include "sspcl_defs.vh"
`default_nettype none

// ***************************************************
// Speed dependent motor current limit
// ***************************************************
module sspcl_limit #(
   parameter W = 16
) (
   input wire clk,
   input wire rst_b,
   input wire update,
   input wire regen_mode,
   input wire signed [W-1:0] rotor_speed_estimate,
   input wire [W-1:0] floor_speed,
   input wire [W-1:0] startup_current_cap,
   input wire [W-1:0] limit_slope,
   input wire [W-1:0] full_speed_current_cap,
   input wire [W-1:0] braking_speed_threshold,
   input wire [W-1:0] braking_current_cap,
   output reg [W-1:0] current_limit
);

   reg [W-1:0] abs_speed;
   reg [2*W:0] ramp;
   reg [W-1:0] lim_d;

   // ***************************************************
   // Profile selection
   // ***************************************************
   always @* begin
      // Most negative speed saturates instead of wrapping
      if (rotor_speed_estimate[W-1])
         abs_speed = (rotor_speed_estimate == {1'b1, {(W-1){1'b0}}}) ?
            {1'b0, {(W-1){1'b1}}} : (~rotor_speed_estimate + {{(W-1){1'b0}}, 1'b1});
      else
         abs_speed = rotor_speed_estimate;
      ramp = {(2*W+1){1'b0}};
      if (regen_mode && (abs_speed > braking_speed_threshold)) begin
         lim_d = braking_current_cap;
      end else if (abs_speed <= floor_speed) begin
         lim_d = startup_current_cap;
      end else begin
         // Linear rise, also used below the braking threshold
         ramp = {{(W+1){1'b0}}, startup_current_cap}
            + {1'b0, ({{W{1'b0}}, abs_speed - floor_speed} * {{W{1'b0}}, limit_slope})};
         // Meeting the full cap defines the low speed threshold
         if (ramp >= {{(W+1){1'b0}}, full_speed_current_cap})
            lim_d = full_speed_current_cap;
         else
            lim_d = ramp[W-1:0];
      end
   end

   // Full cap is read live each update, so run time rewrites take hold
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         current_limit <= {W{1'b0}};
      else if (update)
         current_limit <= lim_d;
   end

endmodule

`default_nettype wire

/* src/sspcl_top.v */
`include "sspcl_defs.vh"
`default_nettype none

module sspcl_top #(
   parameter W = 16
) (
   input wire clk,
   input wire rst_b,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // PWM timing from the modulator
   input wire pwm_cycle_start,
   input wire sector_change,
   input wire [W-1:0] pwm_period,
   input wire [W-1:0] ta,
   input wire [W-1:0] tb,
   input wire [W-1:0] a_start,
   input wire [W-1:0] b_start,
   input wire [W-1:0] zero_start,
   // Shunt ADC
   output reg adc_trigger,
   input wire adc_valid,
   input wire [W-1:0] adc_data,
   // Reconstructed currents in normal mode
   input wire [W-1:0] q_axis_recon,
   input wire [W-1:0] d_axis_recon,
   // Speed and operating quadrant
   input wire signed [W-1:0] rotor_speed_estimate,
   input wire regen_mode,
   // Feedback and limit to the regulators
   output reg [W-1:0] q_axis_current,
   output reg [W-1:0] d_axis_current,
   output wire [W-1:0] current_limit,
   output wire peak_mode
);

   // ***************************************************
   // Register file
   // ***************************************************
   reg [1:0] ctrl_q; // Single shunt and low noise select
   reg [W-1:0] min_shift_window_q; // Phase shift window, zero closes it
   reg [W-1:0] dead_time_q; // Dead time in clock cycles
   reg [W-1:0] sampling_delay_q; // Sampling delay in clock cycles
   reg [W-1:0] floor_speed_q; // Speed below which startup cap applies
   reg [W-1:0] startup_cap_q; // Startup current cap
   reg [W-1:0] slope_q; // Limit rise per speed count
   reg [W-1:0] full_cap_q; // Full speed current cap
   reg [W-1:0] brake_thr_q; // Braking speed threshold
   reg [W-1:0] brake_cap_q; // Braking current cap

   // ***************************************************
   // Peak tracking state
   // ***************************************************
   reg [W-1:0] peak_q; // Largest sample in this sector
   reg [W-1:0] cycle_cnt_q; // Position within PWM cycle
   reg [1:0] trig_state_q; // Which sample is due next
   reg peak_mode_q; // Registered mode flag

   localparam [1:0] ST_WAIT_FIRST = 2'h0;
   localparam [1:0] ST_WAIT_SECOND = 2'h1;
   localparam [1:0] ST_DONE = 2'h2;

   wire [W-1:0] first_sample_point;
   wire [W-1:0] second_sample_point;
   wire apb_write;
   wire apb_read;
   wire addr_hit;
   wire peak_mode_d;

   // Larger of two unsigned samples
   function [W-1:0] larger;
      input [W-1:0] a;
      input [W-1:0] b;
      begin
         larger = (a > b) ? a : b;
      end
   endfunction

   // True for every mapped register offset
   function mapped;
      input [7:0] a;
      begin
         case (a)
            `SSPCL_ADDR_CTRL, `SSPCL_ADDR_MIN_SHIFT, `SSPCL_ADDR_DT_SD,
            `SSPCL_ADDR_FLOOR_SPEED, `SSPCL_ADDR_STARTUP_CAP, `SSPCL_ADDR_SLOPE,
            `SSPCL_ADDR_FULL_CAP, `SSPCL_ADDR_BRAKE_THR, `SSPCL_ADDR_BRAKE_CAP,
            `SSPCL_ADDR_STATUS, `SSPCL_ADDR_LIMIT, `SSPCL_ADDR_SAMPLE_PTS: begin
               mapped = 1'b1;
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
      end
   endfunction

   // ***************************************************
   // APB handshake
   // ***************************************************
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign addr_hit = mapped(paddr);
   assign pslverr = psel & penable & ~addr_hit;
   assign apb_write = psel & penable & pwrite & addr_hit;
   assign apb_read = psel & penable & ~pwrite;

   // Peak mode needs a single shunt and a fully closed window
   assign peak_mode_d = ctrl_q[`SSPCL_CTRL_SINGLE_SHUNT]
      & (min_shift_window_q == `SSPCL_RST_MIN_SHIFT);
   assign peak_mode = peak_mode_q;

   // Register writes, only at the completing access edge
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= `SSPCL_RST_CTRL;
         min_shift_window_q <= `SSPCL_RST_MIN_SHIFT;
         dead_time_q <= `SSPCL_RST_WORD;
         sampling_delay_q <= `SSPCL_RST_WORD;
         floor_speed_q <= `SSPCL_RST_WORD;
         startup_cap_q <= `SSPCL_RST_WORD;
         slope_q <= `SSPCL_RST_WORD;
         full_cap_q <= `SSPCL_RST_FULL_CAP;
         brake_thr_q <= `SSPCL_RST_WORD;
         brake_cap_q <= `SSPCL_RST_WORD;
      end else if (apb_write) begin
         case (paddr)
            `SSPCL_ADDR_CTRL: begin
               ctrl_q <= pwdata[1:0];
            end
            `SSPCL_ADDR_MIN_SHIFT: begin
               min_shift_window_q <= pwdata[`SSPCL_LO_MSB:0];
            end
            `SSPCL_ADDR_DT_SD: begin
               dead_time_q <= pwdata[`SSPCL_LO_MSB:0];
               sampling_delay_q <= pwdata[31:`SSPCL_HI_LSB];
            end
            `SSPCL_ADDR_FLOOR_SPEED: begin
               floor_speed_q <= pwdata[`SSPCL_LO_MSB:0];
            end
            `SSPCL_ADDR_STARTUP_CAP: begin
               startup_cap_q <= pwdata[`SSPCL_LO_MSB:0];
            end
            `SSPCL_ADDR_SLOPE: begin
               slope_q <= pwdata[`SSPCL_LO_MSB:0];
            end
            `SSPCL_ADDR_FULL_CAP: begin
               // Software may rewrite this live for a custom profile
               full_cap_q <= pwdata[`SSPCL_LO_MSB:0];
            end
            `SSPCL_ADDR_BRAKE_THR: begin
               brake_thr_q <= pwdata[`SSPCL_LO_MSB:0];
            end
            `SSPCL_ADDR_BRAKE_CAP: begin
               brake_cap_q <= pwdata[`SSPCL_LO_MSB:0];
            end
            default: begin
               // Read-only offsets ignore writes
            end
         endcase
      end
   end

   // Read mux, combinational so data is valid in the access cycle
   always @* begin
      prdata = 32'h00000000;
      if (apb_read) begin
         case (paddr)
            `SSPCL_ADDR_CTRL: begin
               prdata = {30'h00000000, ctrl_q};
            end
            `SSPCL_ADDR_MIN_SHIFT: begin
               prdata = {16'h0000, min_shift_window_q};
            end
            `SSPCL_ADDR_DT_SD: begin
               prdata = {sampling_delay_q, dead_time_q};
            end
            `SSPCL_ADDR_FLOOR_SPEED: begin
               prdata = {16'h0000, floor_speed_q};
            end
            `SSPCL_ADDR_STARTUP_CAP: begin
               prdata = {16'h0000, startup_cap_q};
            end
            `SSPCL_ADDR_SLOPE: begin
               prdata = {16'h0000, slope_q};
            end
            `SSPCL_ADDR_FULL_CAP: begin
               prdata = {16'h0000, full_cap_q};
            end
            `SSPCL_ADDR_BRAKE_THR: begin
               prdata = {16'h0000, brake_thr_q};
            end
            `SSPCL_ADDR_BRAKE_CAP: begin
               prdata = {16'h0000, brake_cap_q};
            end
            `SSPCL_ADDR_STATUS: begin
               // Peak value in the upper half, mode in bit zero
               prdata = {peak_q, 15'h0000, peak_mode_q};
            end
            `SSPCL_ADDR_LIMIT: begin
               prdata = {16'h0000, current_limit};
            end
            `SSPCL_ADDR_SAMPLE_PTS: begin
               prdata = {second_sample_point, first_sample_point};
            end
            default: begin
               prdata = 32'h00000000;
            end
         endcase
      end
   end

   // ***************************************************
   // Sample scheduling and current limit
   // ***************************************************
   sspcl_sample_sched #(
      .W(W)
   ) u_sched (
      .clk(clk),
      .rst_b(rst_b),
      .load(pwm_cycle_start),
      .low_noise(ctrl_q[`SSPCL_CTRL_LOW_NOISE]),
      .period(pwm_period),
      .ta(ta),
      .tb(tb),
      .a_start(a_start),
      .b_start(b_start),
      .zero_start(zero_start),
      .dead_time(dead_time_q),
      .sampling_delay(sampling_delay_q),
      .first_sample_point(first_sample_point),
      .second_sample_point(second_sample_point)
   );

   sspcl_limit #(
      .W(W)
   ) u_limit (
      .clk(clk),
      .rst_b(rst_b),
      .update(pwm_cycle_start),
      .regen_mode(regen_mode),
      .rotor_speed_estimate(rotor_speed_estimate),
      .floor_speed(floor_speed_q),
      .startup_current_cap(startup_cap_q),
      .limit_slope(slope_q),
      .full_speed_current_cap(full_cap_q),
      .braking_speed_threshold(brake_thr_q),
      .braking_current_cap(brake_cap_q),
      .current_limit(current_limit)
   );

   // ***************************************************
   // Cycle timer and ADC triggers
   // ***************************************************
   // Points load on the start pulse, so triggers count from the next edge
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cycle_cnt_q <= {W{1'b0}};
         trig_state_q <= ST_DONE;
         adc_trigger <= 1'b0;
      end else begin
         adc_trigger <= 1'b0;
         if (pwm_cycle_start) begin
            cycle_cnt_q <= {W{1'b0}};
            trig_state_q <= peak_mode_q ? ST_WAIT_FIRST : ST_DONE;
         end else begin
            cycle_cnt_q <= cycle_cnt_q + {{(W-1){1'b0}}, 1'b1};
            case (trig_state_q)
               ST_WAIT_FIRST: begin
                  // Two triggers per cycle, in order
                  if (peak_mode_q && (cycle_cnt_q == first_sample_point)) begin
                     adc_trigger <= 1'b1;
                     trig_state_q <= ST_WAIT_SECOND;
                  end
               end
               ST_WAIT_SECOND: begin
                  if (peak_mode_q && (cycle_cnt_q == second_sample_point)) begin
                     adc_trigger <= 1'b1;
                     trig_state_q <= ST_DONE;
                  end
               end
               ST_DONE: begin
                  trig_state_q <= ST_DONE;
               end
               default: begin
                  trig_state_q <= ST_DONE;
               end
            endcase
         end
      end
   end

   // ***************************************************
   // Peak tracking
   // ***************************************************
   // A sample in the clearing cycle survives: it starts the new sector
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         peak_q <= {W{1'b0}};
         peak_mode_q <= 1'b0;
      end else begin
         peak_mode_q <= peak_mode_d;
         if (!peak_mode_d) begin
            peak_q <= {W{1'b0}};
         end else if (sector_change) begin
            peak_q <= adc_valid ? adc_data : {W{1'b0}};
         end else if (adc_valid) begin
            // Raw sample kept in the q current format, no rescaling
            peak_q <= larger(peak_q, adc_data);
         end
      end
   end

   // ***************************************************
   // Feedback to the regulators
   // ***************************************************
   // Updated once per PWM cycle, at its start pulse
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q_axis_current <= {W{1'b0}};
         d_axis_current <= {W{1'b0}};
      end else if (pwm_cycle_start) begin
         if (peak_mode_q) begin
            q_axis_current <= peak_q;
            d_axis_current <= {W{1'b0}};
         end else begin
            q_axis_current <= q_axis_recon;
            d_axis_current <= d_axis_recon;
         end
      end
   end

endmodule

`default_nettype wire

/* test/sspcl_props.sv */
`default_nettype none
// Checker on the top ports; it shadows register writes to predict the limit
module sspcl_props #(
   parameter W = 16
) (
   input wire logic clk, rst_b, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic pwm_cycle_start, sector_change, adc_trigger, adc_valid,
   input wire logic [W-1:0] adc_data, q_axis_current, d_axis_current, current_limit,
   input wire logic signed [W-1:0] rotor_speed_estimate,
   input wire logic regen_mode, peak_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [W-1:0] sh [0:15]; // Shadow of the writable words
   logic [W-1:0] pk_q; // Predicted peak
   logic [W:0] spd; // Absolute speed, one bit wider for the most negative value
   logic [2*W+1:0] lin; // Unsaturated ramp
   logic [W-1:0] lim;
   logic brk;
   // Shadow registers follow completed writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 16; i++)
            sh[i] <= '0;
         sh[0] <= 16'h0001;
         sh[6] <= 16'h7FFF;
      end else if (psel && penable && pwrite && pready && paddr < 8'h24) begin
         sh[paddr[5:2]] <= pwdata[W-1:0];
      end
   end
   // Peak model; a sample with the sector change is kept
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         pk_q <= '0;
      else if (sh[1] != '0 || !sh[0][0])
         pk_q <= '0;
      else if (sector_change)
         pk_q <= adc_valid ? adc_data : '0;
      else if (adc_valid && adc_data > pk_q)
         pk_q <= adc_data;
   end
   // Expected limit from live speed and shadowed settings
   always_comb begin
      spd = rotor_speed_estimate[W-1] ? -{1'b1, rotor_speed_estimate} : {1'b0, rotor_speed_estimate};
      brk = regen_mode && spd > {1'b0, sh[7]};
      lin = sh[4] + sh[5] * (spd - sh[3]);
      lim = (lin > sh[6]) ? sh[6] : lin[W-1:0];
   end
   a_dfb_zero: assert property (
      $past(pwm_cycle_start) && peak_mode && $past(peak_mode) |-> d_axis_current == '0)
      else $error("d feedback not zero");
   a_q_peak: assert property (
      $past(pwm_cycle_start) && peak_mode && $past(peak_mode) |-> q_axis_current == $past(pk_q))
      else $error("q feedback not the peak");
   a_mode_exit: assert property (
      (sh[1] != '0 || !sh[0][0]) |=> !peak_mode) else $error("peak mode kept");
   a_trig_off: assert property (
      !peak_mode && !$past(peak_mode) |-> !adc_trigger) else $error("trigger outside peak mode");
   a_trig_pulse: assert property (
      adc_trigger |=> !adc_trigger) else $error("trigger too long");
   a_brake_cap: assert property (
      pwm_cycle_start && brk |=> current_limit == $past(sh[8])) else $error("braking cap wrong");
   a_floor_cap: assert property (
      pwm_cycle_start && !brk && spd <= {1'b0, sh[3]} |=> current_limit == $past(sh[4]))
      else $error("startup cap wrong");
   a_ramp_lim: assert property (
      pwm_cycle_start && !brk && spd > {1'b0, sh[3]} |=> current_limit == $past(lim))
      else $error("ramp limit wrong");
   a_bad_addr: assert property (
      psel && penable && paddr >= 8'h30 |-> pslverr && prdata == '0) else $error("no slave error");
endmodule
bind sspcl_top sspcl_props #(.W(W)) u_props (.*);
`default_nettype wire

/* test/sspcl_pwm_model.sv */
`default_nettype none
// Modulator cycle pulse and shunt converter; answers each trigger once
module sspcl_pwm_model (
   input wire logic clk, rst_b, slow, adc_trigger,
   input wire logic [15:0] period, samp0, samp1,
   output logic pwm_cycle_start, adc_valid,
   output logic [15:0] adc_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt; // Position in the cycle
   logic [3:0] wait_q; // Conversion countdown
   logic idx; // Which sample answers next
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= '0;
         wait_q <= '0;
         idx <= 1'b0;
         pwm_cycle_start <= 1'b0;
         adc_valid <= 1'b0;
         adc_data <= '0;
      end else begin
         cnt <= (cnt == period - 1'b1) ? '0 : cnt + 1'b1;
         pwm_cycle_start <= (cnt == period - 1'b1);
         adc_valid <= (wait_q == 4'h1);
         // Junk between answers, so a stale sample cannot pass
         adc_data <= (wait_q == 4'h1) ? (idx ? samp1 : samp0) : ~adc_data;
         if (wait_q == 4'h1)
            idx <= ~idx;
         if (adc_trigger)
            wait_q <= slow ? 4'h9 : 4'h2;
         else if (wait_q != '0)
            wait_q <= wait_q - 1'b1;
         if (pwm_cycle_start)
            idx <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* test/sspcl_top_tb.sv */
`default_nettype none
module sspcl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] PER = 16'h0258; // 600 cycles per PWM cycle
   // Rows: low noise, ta, tb, a_start, b_start, second point, first point
   localparam logic [111:0] PTS [6] = '{
      {16'h0, 16'h0064, 16'h0050, 16'h012C, 16'h0064, 16'h016D, 16'h009B},
      {16'h0, 16'h0028, 16'h0050, 16'h012C, 16'h0064, 16'h023F, 16'h009B},
      {16'h0, 16'h0064, 16'h0028, 16'h012C, 16'h0064, 16'h016D, 16'h0019},
      {16'h1, 16'h003C, 16'h0046, 16'h0064, 16'h012C, 16'h01B3, 16'h00E1},
      {16'h1, 16'h0028, 16'h0046, 16'h00C8, 16'h012C, 16'h01B3, 16'h0096},
      {16'h1, 16'h0028, 16'h0028, 16'h001E, 16'h012C, 16'h01C2, 16'h0001}};
   // Floor, startup cap, slope, full cap, braking threshold, braking cap
   localparam logic [31:0] LREG [6] = '{32'h64, 32'h200, 32'h4, 32'h1000, 32'h3E8, 32'h300};
   // Rows: regen, speed, expected limit; full cap drops to 0x600 from row 6
   localparam logic [47:0] LIM [8] = '{{16'h0, 16'h0032, 16'h0200}, {16'h0, 16'hFF9C, 16'h0200},
      {16'h0, 16'h012C, 16'h0520}, {16'h0, 16'hF830, 16'h1000}, {16'h1, 16'hFE0C, 16'h0840},
      {16'h1, 16'h03E9, 16'h0300}, {16'h0, 16'h012C, 16'h0520}, {16'h0, 16'h07D0, 16'h0600}};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sector_change = 1'b0, regen_mode = 1'b0;
   logic slow = 1'b0, pready, pslverr, pwm_cycle_start, adc_trigger, adc_valid, peak_mode, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] ta = '0, tb = '0, a_start = '0, b_start = '0, q_axis_recon = '0, d_axis_recon = '0;
   logic [15:0] samp0 = '0, samp1 = '0, adc_data, q_axis_current, d_axis_current, current_limit;
   logic signed [15:0] rotor_speed_estimate = '0;
   logic [15:0] zero_start = '0;
   int error_cnt = 0, check_count = 0, cyc = 0;
   sspcl_top #(.W(16)) uut (.*, .pwm_period(PER));
   sspcl_pwm_model u_pwm (.*, .period(PER));
   initial begin
      forever #10 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task wrap_up;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One bus transfer; read data and error taken at the ready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Returns one edge after a cycle start, when latched outputs are settled
   task wait_start;
      do @(posedge clk); while (pwm_cycle_start !== 1'b1);
      @(posedge clk);
   endtask
   task t_regs;
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h7FFF);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 8'h28, 32'hFFFF);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   task t_points;
      apb(1'b1, 8'h08, 32'h0005000A);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'h00, {30'h0, PTS[i][96], 1'b1});
         ta <= PTS[i][95:80];
         tb <= PTS[i][79:64];
         a_start <= PTS[i][63:48];
         b_start <= PTS[i][47:32];
         zero_start <= PTS[i][63:48] + 16'h00DC;
         wait_start();
         wait_start();
         apb(1'b0, 8'h2C, 32'h0);
         chk(rd, PTS[i][31:0]);
      end
   endtask
   task t_peak;
      apb(1'b1, 8'h00, 32'h1);
      q_axis_recon <= 16'h0ABC;
      d_axis_recon <= 16'h0DEF;
      slow <= 1'b1;
      ta <= 16'h0064;
      tb <= 16'h0050;
      a_start <= 16'h012C;
      b_start <= 16'h0064;
      samp0 <= 16'h0120;
      samp1 <= 16'h0300;
      wait_start();
      wait_start();
      chk(32'(q_axis_current), 32'h0300);
      chk(32'(d_axis_current), 32'h0);
      samp0 <= 16'h0100;
      samp1 <= 16'h0200;
      wait_start();
      chk(32'(q_axis_current), 32'h0300);
      sector_change <= 1'b1;
      @(posedge clk) sector_change <= 1'b0;
      wait_start();
      chk(32'(q_axis_current), 32'h0200);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h02000001);
   endtask
   task t_window;
      apb(1'b1, 8'h04, 32'h1);
      wait_start();
      wait_start();
      chk(32'(q_axis_current), 32'h0ABC);
      chk(32'(d_axis_current), 32'h0DEF);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h04, 32'h0);
   endtask
   task t_limit;
      for (int i = 0; i < 6; i++)
         apb(1'b1, 8'h0C + 8'(4 * i), LREG[i]);
      for (int i = 0; i < 8; i++) begin
         if (i == 6)
            apb(1'b1, 8'h18, 32'h600);
         regen_mode <= LIM[i][32];
         rotor_speed_estimate <= LIM[i][31:16];
         wait_start();
         chk(32'(current_limit), 32'(LIM[i][15:0]));
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_points();
      t_peak();
      t_window();
      t_limit();
      wrap_up();
   end
endmodule
`default_nettype wire
